/* File: pamx_pkg.sv */
package pamx_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFF_FUNC_CTRL = 8'h30;
  localparam logic [7:0] OFF_ALT_THREE = 8'h50;
  localparam logic [7:0] OFF_ALT_FOUR = 8'h54;
  localparam logic [7:0] OFF_PAD_LEVEL = 8'h58;
  localparam logic [7:0] OFF_ROUTE_STATUS = 8'h5C;

  // Reset values.
  localparam logic [31:0] FUNC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ALT_THREE_RST = 32'h0000_0000;
  localparam logic [31:0] ALT_FOUR_RST = 32'h0000_0000;

  // Implemented bits of the alternate registers; the rest read as zero.
  localparam logic [31:0] ALT_THREE_MASK = 32'h0000_0300;
  localparam logic [31:0] ALT_FOUR_MASK = 32'h0000_4333;

  // Field positions in the function control register.
  localparam int SCHMITT_LSB = 16;
  localparam int SCHMITT_W = 16;

  // Qualifier positions in the alternate registers.
  localparam int Q13_POS = 9;
  localparam int Q12_POS = 8;
  localparam int Q11_POS = 9;
  localparam int Q10_POS = 8;
  localparam int Q9_POS = 1;
  localparam int Q8_POS = 0;
  localparam int Q7_POS = 14;
  localparam int Q6_POS = 5;
  localparam int Q5_POS = 4;

  // Covered pin range.
  localparam int PIN_LO = 5;
  localparam int PIN_HI = 15;
  localparam int PIN_QHI = 13;
  localparam int ROUTE_W = 22;

  // Route of one pin.
  typedef enum logic [1:0] {
    PAMX_FN_GPIO = 2'b00,
    PAMX_FN_PRI = 2'b01,
    PAMX_FN_ALT = 2'b10
  } pamx_fn_t;

endpackage

/* File: pamx_cfg_if.sv */
interface pamx_cfg_if;
  logic [31:0] funcCtrl;
  logic [31:0] altThree;
  logic [31:0] altFour;
  logic [15:0] padLevel;
  logic [pamx_pkg::ROUTE_W-1:0] routeCode;

  // Register file side.
  modport regs (
    output funcCtrl,
    output altThree,
    output altFour,
    input padLevel,
    input routeCode
  );

  // Multiplexer core side.
  modport core (
    input funcCtrl,
    input altThree,
    input altFour,
    output padLevel,
    output routeCode
  );
endinterface

/* File: pamx_regs.sv */
module pamx_regs (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // Register port.
  input wire logic [pamx_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pamx_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [pamx_pkg::DATA_W-1:0] regRdData_ff,
  // Configuration toward the core.
  pamx_cfg_if.regs cfg
);

  logic [31:0] funcCtrl_ff;
  logic [31:0] altThree_ff;
  logic [31:0] altFour_ff;

  // Address decode.
  wire hitFunc = (regAddr == pamx_pkg::OFF_FUNC_CTRL);
  wire hitAltThree = (regAddr == pamx_pkg::OFF_ALT_THREE);
  wire hitAltFour = (regAddr == pamx_pkg::OFF_ALT_FOUR);
  wire hitLevel = (regAddr == pamx_pkg::OFF_PAD_LEVEL);
  wire hitRoute = (regAddr == pamx_pkg::OFF_ROUTE_STATUS);

  // Read selection; an unmapped address reads zero.
  wire [31:0] rdMux =
    hitFunc ? funcCtrl_ff :
    hitAltThree ? altThree_ff :
    hitAltFour ? altFour_ff :
    hitLevel ? {16'h0000, cfg.padLevel} :
    hitRoute ? {10'h000, cfg.routeCode} : 32'h0000_0000;

  // reset to zero.
  // Writes land in the cycle of the strobe; unmapped writes are dropped.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      funcCtrl_ff <= pamx_pkg::FUNC_CTRL_RST;
      altThree_ff <= pamx_pkg::ALT_THREE_RST;
      altFour_ff <= pamx_pkg::ALT_FOUR_RST;
    end else if (clkEn && regWr) begin
      if (hitFunc) funcCtrl_ff <= regWrData;
      if (hitAltThree) altThree_ff <= regWrData & pamx_pkg::ALT_THREE_MASK;
      if (hitAltFour) altFour_ff <= regWrData & pamx_pkg::ALT_FOUR_MASK;
    end
  end

  // Read data stands for one enabled cycle after an enabled read strobe; while the enable is low it holds.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regRdData_ff <= 32'h0000_0000;
    end else if (clkEn) begin
      regRdData_ff <= regRd ? rdMux : 32'h0000_0000;
    end
  end

  assign cfg.funcCtrl = funcCtrl_ff;
  assign cfg.altThree = altThree_ff;
  assign cfg.altFour = altFour_ff;

endmodule

/* File: pamx_pin_cell.sv */
module pamx_pin_cell (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // Route of this pin.
  input wire pamx_pkg::pamx_fn_t fnCode,
  // Sources that may drive the pin.
  input wire logic gpioOut,
  input wire logic gpioOe,
  input wire logic priOut,
  input wire logic priOe,
  input wire logic altOut,
  input wire logic altOe,
  // Pad.
  input wire logic padIn,
  output logic padOut_ff,
  output logic padOe_ff,
  // Pad level returned to the selected owner only.
  output logic gpioIn_ff,
  output logic priIn_ff,
  output logic altIn_ff
);

  // Output selection by route.
  wire selGpio = (fnCode == pamx_pkg::PAMX_FN_GPIO);
  wire selPri = (fnCode == pamx_pkg::PAMX_FN_PRI);
  wire selAlt = (fnCode == pamx_pkg::PAMX_FN_ALT);
  wire nxt_padOut = selAlt ? altOut : (selPri ? priOut : gpioOut);
  wire nxt_padOe = selAlt ? altOe : (selPri ? priOe : (selGpio & gpioOe));

  // Registered pad drive and gated input return.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      padOut_ff <= 1'b0;
      padOe_ff <= 1'b0;
      gpioIn_ff <= 1'b0;
      priIn_ff <= 1'b0;
      altIn_ff <= 1'b0;
    end else if (clkEn) begin
      padOut_ff <= nxt_padOut;
      padOe_ff <= nxt_padOe;
      gpioIn_ff <= selGpio & padIn;
      priIn_ff <= selPri & padIn;
      altIn_ff <= selAlt & padIn;
    end
  end

endmodule

/* File: pamx_pin_mux.sv */
// Overview of operation
// - Function control register resets to zero; all pins GPIO, Schmitt triggers off.
// - Bits 31 to 16 enable the input Schmitt trigger of pins 15 to 0.
// - Pin 15 is GPIO when select is 0, PWM group 0 channel 3 when 1.
// - Pin 14 is GPIO when select is 0, PWM group 0 channel 2 when 1.
// - Pin 13 with qualifier four bit 9: GPIO, PWM0 channel 1, or UART5 transmit.
// - Pin 12 with qualifier four bit 8: GPIO, PWM0 channel 0, or UART5 receive.
// - Pin 11 with qualifier three bit 9: GPIO, I2C1 clock, or PWM1 channel 3.
// - Pin 10 with qualifier three bit 8: GPIO, I2C1 data, or PWM1 channel 2.
// - Pin 9 with qualifier four bit 1: GPIO, I2C0 clock, or UART1 clear-to-send.
// - Pin 8 with qualifier four bit 0: GPIO, I2C0 data, or UART1 request-to-send.
// - Pin 7 with qualifier four bit 14: GPIO, analog channel 7, or reference voltage.
// - Pin 6 with qualifier four bit 5: GPIO, analog channel 6, or UART3 transmit.
// - Pin 5 with qualifier four bit 4: GPIO, analog channel 5, or UART3 receive.
module pamx_pin_mux (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // Register port.
  input wire logic [pamx_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pamx_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [pamx_pkg::DATA_W-1:0] regRdData,
  // Package pads of pins 15 to 5.
  input wire logic [15:5] padIn,
  output logic [15:5] padOut,
  output logic [15:5] padOe,
  // Input Schmitt trigger enables of pins 15 to 0.
  output logic [15:0] schmittEn,
  // General-purpose port logic.
  input wire logic [15:5] gpioOut,
  input wire logic [15:5] gpioOe,
  output logic [15:5] gpioIn,
  // Function chosen by the select bit alone (PWM0, I2C, analog).
  input wire logic [15:5] priOut,
  input wire logic [15:5] priOe,
  output logic [15:5] priIn,
  // Function chosen by select and qualifier together (UART, PWM1, reference).
  input wire logic [13:5] altOut,
  input wire logic [13:5] altOe,
  output logic [13:5] altIn
);

  // Configuration shared with the register file.
  pamx_cfg_if cfg ();

  logic [pamx_pkg::DATA_W-1:0] rdData;
  logic [15:0] schmittEn_ff;
  logic [15:5] padLevel_ff;
  logic [15:5] padOutCell;
  logic [15:5] padOeCell;
  logic [15:5] gpioInCell;
  logic [15:5] priInCell;
  logic [15:5] altInCell;

  // Register file and bus slave.
  pamx_regs u_regs (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData_ff(rdData),
    .cfg(cfg.regs)
  );

  // Per-pin select bits from the low half of the control register.
  wire [15:5] fnSel = cfg.funcCtrl[15:5];

  // Qualifier bits gathered per pin; pins 15 and 14 have none.
  // pin 15 select only.
  wire qual15 = 1'b0;
  wire qual14 = 1'b0;
  wire qual13 = cfg.altFour[pamx_pkg::Q13_POS];
  wire qual12 = cfg.altFour[pamx_pkg::Q12_POS];
  wire qual11 = cfg.altThree[pamx_pkg::Q11_POS];
  wire qual10 = cfg.altThree[pamx_pkg::Q10_POS];
  wire qual9 = cfg.altFour[pamx_pkg::Q9_POS];
  wire qual8 = cfg.altFour[pamx_pkg::Q8_POS];
  wire qual7 = cfg.altFour[pamx_pkg::Q7_POS];
  wire qual6 = cfg.altFour[pamx_pkg::Q6_POS];
  wire qual5 = cfg.altFour[pamx_pkg::Q5_POS];

  wire [15:5] qual = {qual15, qual14, qual13, qual12, qual11, qual10,
                      qual9, qual8, qual7, qual6, qual5};

  // Feedback for software: pad levels and the route of each pin.
  assign cfg.padLevel = {padLevel_ff, 5'h00};

  // Schmitt enables follow the upper half with one register stage.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      schmittEn_ff <= 16'h0000;
      padLevel_ff <= 11'h000;
    end else if (clkEn) begin
      schmittEn_ff <= cfg.funcCtrl[pamx_pkg::SCHMITT_LSB +: pamx_pkg::SCHMITT_W];
      padLevel_ff <= padIn;
    end
  end

  // One decoder and one pad cell per covered pin.
  genvar p;
  generate
    for (p = pamx_pkg::PIN_LO; p <= pamx_pkg::PIN_HI; p++) begin : g_pin
      pamx_pkg::pamx_fn_t fnCode;
      wire altSrcOut;
      wire altSrcOe;

      // a qualifier without its select bit keeps the pin on GPIO.
      assign fnCode = !fnSel[p] ? pamx_pkg::PAMX_FN_GPIO :
                      (qual[p] ? pamx_pkg::PAMX_FN_ALT : pamx_pkg::PAMX_FN_PRI);
      assign cfg.routeCode[2*(p-pamx_pkg::PIN_LO) +: 2] = fnCode;

      // Pins above 13 have no qualified function, so nothing feeds it.
      if (p > pamx_pkg::PIN_QHI) begin : g_noalt
        assign altSrcOut = 1'b0;
        assign altSrcOe = 1'b0;
      end else begin : g_alt
        assign altSrcOut = altOut[p];
        assign altSrcOe = altOe[p];
        assign altIn[p] = altInCell[p];
      end

      pamx_pin_cell u_cell (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .fnCode(fnCode),
        .gpioOut(gpioOut[p]),
        .gpioOe(gpioOe[p]),
        .priOut(priOut[p]),
        .priOe(priOe[p]),
        .altOut(altSrcOut),
        .altOe(altSrcOe),
        .padIn(padIn[p]),
        .padOut_ff(padOutCell[p]),
        .padOe_ff(padOeCell[p]),
        .gpioIn_ff(gpioInCell[p]),
        .priIn_ff(priInCell[p]),
        .altIn_ff(altInCell[p])
      );
    end
  endgenerate

  // Outputs straight from the flip-flops of the cells, the Schmitt stage and the register file.
  assign padOut = padOutCell;
  assign padOe = padOeCell;
  assign gpioIn = gpioInCell;
  assign priIn = priInCell;
  assign schmittEn = schmittEn_ff;
  assign regRdData = rdData;

endmodule

/* File: pamx_pad_model.sv */
module pamx_pad_model (
  // Pads as seen from the board.
  input wire logic [15:5] padOut,
  input wire logic [15:5] padOe,
  output logic [15:5] padIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // Board pull-ups hold an undriven pad high.
  assign padIn = (padOut & padOe) | ~padOe;
endmodule

/* File: pamx_pin_mux_checker.sv */
module pamx_pin_mux_checker (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  // Pads and owners.
  input wire logic [15:5] padIn,
  input wire logic [15:5] padOut,
  input wire logic [15:5] padOe,
  input wire logic [15:0] schmittEn,
  input wire logic [15:5] gpioOut,
  input wire logic [15:5] gpioIn,
  input wire logic [15:5] priOe,
  input wire logic [15:5] priIn,
  input wire logic [13:5] altIn,
  input wire logic [15:5] gpioOe,
  input wire logic [13:5] altOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctl_ff;
  logic [31:0] a3_ff;
  logic [31:0] a4_ff;
  logic [1:0] quiet_ff;
  wire logic quiet = quiet_ff == 2'h3;
  // Qualifier of each pin, zero for the select-only pins.
  wire logic [15:5] qual = {2'h0, a4_ff[9:8], a3_ff[9:8], a4_ff[1:0], a4_ff[14], a4_ff[5:4]};
  wire logic [15:5] eGpio = ~ctl_ff[15:5];
  wire logic [15:5] ePri = ctl_ff[15:5] & ~qual;
  wire logic [13:5] eAlt = ctl_ff[13:5] & qual[13:5];

  // Shadow the registers and count quiet enabled cycles since the last write or freeze.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl_ff <= 32'h0;
      a3_ff <= 32'h0;
      a4_ff <= 32'h0;
      quiet_ff <= 2'h0;
    end else if (!clkEn) begin
      quiet_ff <= 2'h0;
    end else if (regWr) begin
      quiet_ff <= 2'h0;
      if (regAddr == pamx_pkg::OFF_FUNC_CTRL) ctl_ff <= regWrData;
      if (regAddr == pamx_pkg::OFF_ALT_THREE) a3_ff <= regWrData;
      if (regAddr == pamx_pkg::OFF_ALT_FOUR) a4_ff <= regWrData;
    end else if (!quiet) begin
      quiet_ff <= quiet_ff + 2'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_ctlWr;
    clkEn && regWr && regAddr == pamx_pkg::OFF_FUNC_CTRL;
  endsequence
  sequence s_ctlSettle;
    s_ctlWr ##1 (clkEn && !regWr) ##1 1'b1;
  endsequence

  AST_RST_IDLE: assert property ($rose(reset_n) |-> padOe == '0 && schmittEn == '0)
    else $error("Outputs not idle after reset.");
  AST_SCHMITT: assert property (s_ctlSettle |-> schmittEn == $past(regWrData[31:16], 2))
    else $error("Schmitt enables differ from control bits.");
  AST_RD_CTRL: assert property (clkEn && regRd && regAddr == pamx_pkg::OFF_FUNC_CTRL |=>
    regRdData == $past(ctl_ff))
    else $error("Control register read back wrong.");
  AST_GPIO_IN: assert property (quiet |-> gpioIn == (eGpio & $past(padIn)))
    else $error("GPIO input route wrong.");
  AST_PRI_IN: assert property (quiet |-> priIn == (ePri & $past(padIn)))
    else $error("Select-only input route wrong.");
  AST_ALT_IN: assert property (quiet |-> altIn == (eAlt & $past(padIn[13:5])))
    else $error("Qualified input route wrong.");
  AST_GPIO_OUT: assert property (quiet |-> (padOut & eGpio) == ($past(gpioOut) & eGpio))
    else $error("GPIO drive route wrong.");
  AST_PRI_OE: assert property (quiet |-> (padOe & ePri) == ($past(priOe) & ePri))
    else $error("Select-only enable route wrong.");
  AST_ALT_OUT: assert property (quiet |-> (padOut[13:5] & eAlt) == ($past(altOut) & eAlt))
    else $error("Qualified drive route wrong.");
  AST_GPIO_OE: assert property (quiet |-> (padOe & eGpio) == ($past(gpioOe) & eGpio))
    else $error("GPIO enable route wrong.");
endmodule

bind pamx_pin_mux pamx_pin_mux_checker u_pamx_pin_mux_checker (.clk_sys, .reset_n, .regAddr,
  .clkEn, .regWrData, .regWr, .regRd, .regRdData, .padIn, .padOut, .padOe, .schmittEn, .gpioOut,
  .gpioIn, .priOe, .priIn, .altIn, .gpioOe, .altOut);

/* File: tb_pamx_pin_mux.sv */
module tb_pamx_pin_mux;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData, rdv;
  logic [15:5] padIn, padOut, padOe, gpioIn, priIn;
  logic [15:5] gpioOut = '0, gpioOe = '0, priOut = '0, priOe = '0;
  logic [13:5] altOut = '0, altOe = '0, altIn;
  logic [15:0] schmittEn;
  int err_total = 0;
  int n_checks = 0;
  int qpos [13:5] = '{9, 8, 9, 8, 1, 0, 14, 5, 4};

  // Free-running system clock.
  always #10 clk_sys = ~clk_sys;

  pamx_pin_mux u_pamx_pin_mux (.clk_sys, .reset_n, .clkEn, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .padIn, .padOut, .padOe, .schmittEn, .gpioOut, .gpioOe, .gpioIn,
    .priOut, .priOe, .priIn, .altOut, .altOe, .altIn);
  pamx_pad_model u_pamx_pad_model (.padOut, .padOe, .padIn);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic settle;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // Uniform select and qualifier combinations, then one qualifier at a time.
  task automatic t_routes;
    logic [31:0] q;
    for (int k = 0; k < 4; k++) begin
      wr(pamx_pkg::OFF_ALT_THREE, k[1] ? 32'hFFFF_FFFF : 32'h0);
      wr(pamx_pkg::OFF_ALT_FOUR, k[1] ? 32'hFFFF_FFFF : 32'h0);
      wr(pamx_pkg::OFF_FUNC_CTRL, {16'hA5C3 ^ 16'(k), k[0] ? 16'hFFFF : 16'h0});
      settle();
      chk(32'(schmittEn), 32'(16'hA5C3 ^ 16'(k)));
      chk(32'(gpioIn), k[0] ? 32'h0 : 32'h7FF);
      chk(32'(priIn), k == 1 ? 32'h7FF : (k == 3 ? 32'h600 : 32'h0));
      chk(32'(altIn), k == 3 ? 32'h1FF : 32'h0);
    end
    for (int p = 5; p < 14; p++) begin
      q = 32'h1 << qpos[p];
      wr(pamx_pkg::OFF_ALT_THREE, (p == 10 || p == 11) ? q : 32'h0);
      wr(pamx_pkg::OFF_ALT_FOUR, (p == 10 || p == 11) ? 32'h0 : q);
      settle();
      chk(32'(altIn), 32'h1 << (p - 5));
      chk(32'(priIn), 32'h7FF & ~(32'h1 << (p - 5)));
    end
  endtask

  // Drive paths on the GPIO route and on the select-only route.
  task automatic t_drive;
    @(posedge clk_sys);
    gpioOe <= 11'h7FF;
    gpioOut <= 11'h5A5;
    priOut <= 11'h2DA;
    priOe <= 11'h3C3;
    wr(pamx_pkg::OFF_ALT_FOUR, 32'h0);
    wr(pamx_pkg::OFF_ALT_THREE, 32'h0);
    wr(pamx_pkg::OFF_FUNC_CTRL, 32'h0);
    settle();
    chk(32'(padOut), 32'h5A5);
    chk(32'(gpioIn), 32'h5A5);
    wr(pamx_pkg::OFF_FUNC_CTRL, 32'h0000_FFE0);
    settle();
    chk(32'(padOe), 32'h3C3);
    chk(32'(padOut & padOe), 32'h2C2);
    // Qualified route: pins 13 to 5 take the alternate source, 15 and 14 stay primary.
    @(posedge clk_sys);
    altOut <= 9'h155;
    altOe <= 9'h1F0;
    wr(pamx_pkg::OFF_ALT_FOUR, 32'hFFFF_FFFF);
    wr(pamx_pkg::OFF_ALT_THREE, 32'hFFFF_FFFF);
    settle();
    chk(32'(padOe), 32'h3F0);
    chk(32'(padOut & padOe), 32'h350);
    chk(32'(altIn), 32'h15F);
  endtask

  // A low clock enable drops strobes and holds every output and register.
  task automatic t_freeze;
    @(posedge clk_sys);
    clkEn <= 1'b0;
    priOut <= 11'h000;
    altOut <= 9'h000;
    wr(pamx_pkg::OFF_FUNC_CTRL, 32'hFFFF_0000);
    settle();
    chk(32'(schmittEn), 32'h0);
    chk(32'(padOut & padOe), 32'h350);
    @(posedge clk_sys);
    clkEn <= 1'b1;
    rd(pamx_pkg::OFF_FUNC_CTRL, rdv);
    chk(rdv, 32'h0000_FFE0);
  endtask

  // Unmapped access leaves the control register alone and reads zero.
  task automatic t_regs;
    wr(pamx_pkg::OFF_FUNC_CTRL, 32'h1234_ABCD);
    wr(8'h60, 32'hFFFF_FFFF);
    rd(pamx_pkg::OFF_FUNC_CTRL, rdv);
    chk(rdv, 32'h1234_ABCD);
    rd(8'h60, rdv);
    chk(rdv, 32'h0);
    rd(pamx_pkg::OFF_ROUTE_STATUS, rdv);
    chk(rdv, 32'h0012_22A8);
    wr(pamx_pkg::OFF_ALT_FOUR, 32'hFFFF_FFFF);
    rd(pamx_pkg::OFF_ALT_FOUR, rdv);
    chk(rdv, 32'h0000_4333);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    chk(32'(padOe), 32'h0);
    rd(pamx_pkg::OFF_FUNC_CTRL, rdv);
    chk(rdv, 32'h0);
    chk(32'(schmittEn), 32'h0);
    t_routes();
    t_drive();
    t_freeze();
    t_regs();
    conclude();
  end

  // Watchdog against a hang.
  initial begin
    #200us;
    err_total++;
    conclude();
  end
endmodule
